// ### design/usp_pkg.sv
// Shared constants and types of the serial port.
package usp_pkg;

  // ********************************
  // Register word indices (bus address bits 5:2; byte offset is four times the index)
  // ********************************
  localparam logic [3:0] USP_IDX_INTCTL = 4'h0;
  localparam logic [3:0] USP_IDX_PFLAG = 4'h1;
  localparam logic [3:0] USP_IDX_PEN = 4'h2;
  localparam logic [3:0] USP_IDX_PPRI = 4'h3;
  localparam logic [3:0] USP_IDX_RXCTL = 4'h4;
  localparam logic [3:0] USP_IDX_TXBUF = 4'h5;
  localparam logic [3:0] USP_IDX_TXCTL = 4'h6;
  localparam logic [3:0] USP_IDX_BAUD = 4'h7;
  localparam logic [3:0] USP_IDX_RXBUF = 4'h8;

  // ********************************
  // Field positions
  // ********************************
  localparam int USP_GIE_BIT = 7;
  localparam int USP_PEIE_BIT = 6;
  localparam int USP_RCIRQ_BIT = 5;
  localparam int USP_TXIRQ_BIT = 4;
  localparam int USP_PE_BIT = 7;
  localparam int USP_RX9_BIT = 6;
  localparam int USP_SINGLE_RECEIVE_ENABLE_BIT = 5;
  localparam int USP_CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int USP_ADDRESS_DETECT_ENABLE_BIT = 3;
  localparam int USP_FRAMING_ERROR_BIT = 2;
  localparam int USP_OVERRUN_ERROR_BIT = 1;
  localparam int USP_RX_NINTH_BIT_BIT = 0;
  localparam int USP_CLOCK_SOURCE_MASTER_SELECT_BIT = 7;
  localparam int USP_TX9_BIT = 6;
  localparam int USP_TRANSMIT_ENABLE_BIT = 5;
  localparam int USP_SYNC_BIT = 4;
  localparam int USP_HIGH_SPEED_BAUD_SELECT_BIT = 2;
  localparam int USP_SHIFT_EMPTY_STATUS_BIT = 1;
  localparam int USP_TX_NINTH_BIT_BIT = 0;

  // ********************************
  // Reset values and timing counts
  // ********************************
  localparam logic [7:0] USP_RST_REG = 8'h00;
  localparam logic [7:0] USP_RST_TXCTL = 8'h02;
  localparam logic [3:0] USP_OS_LAST = 4'hf;
  localparam logic [3:0] USP_OS_HALF = 4'h8;
  localparam logic [3:0] USP_SAMPLE_A = 4'h7;
  localparam logic [3:0] USP_SAMPLE_C = 4'h9;
  localparam logic [1:0] USP_LOW_PRESCALE_LAST = 2'h3;
  localparam logic [3:0] USP_BITS_8 = 4'h7;
  localparam logic [3:0] USP_BITS_9 = 4'h8;

  // ********************************
  // State types
  // ********************************
  typedef enum logic [2:0] {USP_TX_IDLE, USP_TX_START, USP_TX_DATA, USP_TX_STOP} usp_tx_state_t;
  typedef enum logic [1:0] {USP_RX_IDLE, USP_RX_START, USP_RX_DATA, USP_RX_STOP} usp_rx_state_t;

endpackage

// ### design/usp_baud.sv
// Baud generator producing the sixteen-times oversampling tick.
`timescale 1ns/100ps
module usp_baud
  import usp_pkg::*;
#(
  parameter int DIV_W = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic high_speed_baud_select,
  input wire logic [DIV_W-1:0] baud_divisor,
  // Tick out
  output logic os_tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [1:0] pre;
    logic tick;
  } usp_baud_state_t;

  usp_baud_state_t s;
  usp_baud_state_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run)
    begin
      next_s.cnt = '0;
      next_s.pre = 2'h0;
    end
    else if (s.cnt == baud_divisor)
    begin
      next_s.cnt = '0;
      // R24 speed select
      if (high_speed_baud_select || s.pre == USP_LOW_PRESCALE_LAST)
      begin
        next_s.pre = 2'h0;
        next_s.tick = 1'b1;
      end
      else
      begin
        next_s.pre = s.pre + 2'h1;
      end
    end
    else
    begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign os_tick = s.tick;

endmodule // usp_baud

// ### design/usp_rx.sv
// Receive data recovery: oversampling front end and bit-rate shifter.
`timescale 1ns/100ps
module usp_rx
  import usp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic os_tick,
  input wire logic enable,
  input wire logic nine_bit,
  input wire logic rx_line,
  // Result
  output logic frame_done,
  output logic [8:0] frame_data,
  output logic frame_err
);

  typedef struct packed {
    usp_rx_state_t st;
    logic [3:0] os;
    logic [3:0] bits;
    logic [8:0] shreg;
    logic [2:0] smp;
    logic done;
    logic [8:0] data;
    logic err;
  } usp_rx_reg_t;

  usp_rx_reg_t s;
  usp_rx_reg_t next_s;
  logic maj;

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    maj = (s.smp[0] & s.smp[1]) | (s.smp[0] & s.smp[2]) | (s.smp[1] & s.smp[2]);
    if (!enable)
    begin
      next_s.st = USP_RX_IDLE;
    end
    else if (os_tick)
    begin
      next_s.os = s.os + 4'h1;
      // R17 sixteen-times sampling
      if (s.os >= USP_SAMPLE_A && s.os <= USP_SAMPLE_C)
        next_s.smp = {s.smp[1:0], rx_line};
      case (s.st)
        USP_RX_IDLE:
        begin
          next_s.os = 4'h1;
          if (!rx_line)
            next_s.st = USP_RX_START;
        end
        USP_RX_START:
          if (s.os == USP_OS_LAST)
          begin
            next_s.bits = 4'h0;
            next_s.st = maj ? USP_RX_IDLE : USP_RX_DATA;
          end
        USP_RX_DATA:
          if (s.os == USP_OS_LAST)
          begin
            // R2 least significant bit first
            next_s.shreg = {maj, s.shreg[8:1]};
            next_s.bits = s.bits + 4'h1;
            // R1 eight or nine data bits
            if (s.bits == (nine_bit ? USP_BITS_9 : USP_BITS_8))
              next_s.st = USP_RX_STOP;
          end
        USP_RX_STOP:
          if (s.os == USP_OS_LAST)
          begin
            next_s.done = 1'b1;
            next_s.data = nine_bit ? s.shreg : {1'b0, s.shreg[8:1]};
            next_s.err = !maj;
            next_s.st = USP_RX_IDLE;
          end
        default:
          next_s.st = USP_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign frame_done = s.done;
  assign frame_data = s.data;
  assign frame_err = s.err;

endmodule // usp_rx

// ### design/usp_top.sv
// Serial port top: register slave, transmitter, receiver hookup and pins.
//
// What this block does
// R1 - Async frames are NRZ: start bit, eight or nine data bits, one stop bit.
// R2 - Transmitter and receiver shift the least significant bit first.
// R3 - An 8-bit baud generator derives bit timing from the baud divisor.
// R4 - Generator runs at 16x or 64x bit rate by the speed select bit.
// R5 - Transmitter and receiver run independently, sharing format and baud rate.
// R6 - No hardware parity; software may carry parity in the ninth bit.
// R7 - Asynchronous operation halts while the device sleeps.
// R8 - Mode bit clear selects asynchronous mode, set selects synchronous mode.
// R9 - Shift register reloads only after the stop bit (after the last data bit in sync mode), then at once if waiting.
// R10 - Buffer to shifter move takes one cycle, then buffer-empty flag sets.
// R11 - Buffer-empty flag ignores enable, cannot be cleared, clears on buffer write.
// R12 - Transmit interrupt request only while buffer-empty flag and its enable set.
// R13 - Read-only shift-empty bit reads one when shifter empty; no interrupt.
// R14 - Setting transmit enable while the buffer is empty also sets the buffer-empty flag.
// R15 - In nine-bit mode the stored ninth bit is sent as ninth data bit.
// R16 - Software programs baud, mode, enables, ninth bit, then writes buffer.
// R17 - Receiver samples the line at sixteen times baud feeding a bit shifter.
// R18 - With continuous receive, completed character sets flag and may interrupt.
// R19 - Errors show beside ninth bit; clearing continuous receive clears them.
// R20 - Address detect filters characters; cleared, every character is buffered.
// R21 - Port enable hands both pins to the serial function.
// R22 - Synchronous master drives shift clock and works half-duplex.
// R23 - With address detect in nine-bit mode, only characters with ninth bit one are accepted.
// R24 - Speed select set chooses 16x rate, cleared chooses 64x rate.
`timescale 1ns/100ps
module usp_top
  import usp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Power state
  input wire logic sleep_mode,
  // Clock/transmit pin
  input wire logic ck_tx_in,
  output logic ck_tx_out,
  output logic ck_tx_oe_n,
  // Data/receive pin
  input wire logic dt_rx_in,
  output logic dt_rx_out,
  output logic dt_rx_oe_n,
  // Interrupt requests
  output logic tx_irq,
  output logic rx_irq,
  output logic cpu_irq
);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
    logic [7:0] interrupt_master_control;
    logic [7:0] peripheral_enable_one;
    logic [7:0] peripheral_priority_one;
    logic port_enable;
    logic nine_bit_rx_select;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic framing_error;
    logic overrun_error;
    logic rx_ninth_bit;
    logic clock_source_master_select;
    logic nine_bit_tx_select;
    logic transmit_enable;
    logic sync_mode;
    logic high_speed_baud_select;
    logic tx_ninth_bit;
    logic [7:0] baud_divisor;
    logic [7:0] transmit_buffer;
    logic [7:0] receive_buffer;
    logic tx_buf_full;
    logic transmit_buffer_empty_flag;
    logic receive_complete_flag;
    usp_tx_state_t txs;
    logic [8:0] tx_shift_register;
    logic [3:0] tx_bits;
    logic [3:0] tx_os;
    logic rx_meta;
    logic rx_sync;
    logic ck_out;
    logic ck_oe_n;
    logic dt_out;
    logic dt_oe_n;
    logic tx_irq;
    logic rx_irq;
    logic cpu_irq;
  } usp_state_t;

  usp_state_t s;
  usp_state_t next_s;

  logic os_tick;
  logic rx_done;
  logic [8:0] rx_data;
  logic rx_framing_error;
  logic baud_run;
  logic rx_enable;
  logic tx_busy;

  // ********************************
  // Baud generator and receiver
  // ********************************
  // R7 sleep halt
  assign baud_run = s.port_enable && !sleep_mode;
  assign tx_busy = (s.txs != USP_TX_IDLE);
  // R22 half duplex
  assign rx_enable = baud_run && s.continuous_receive_enable && !s.overrun_error
                     && !(s.sync_mode && tx_busy);

  // R3 R5 shared baud
  usp_baud #(
    .DIV_W(8)
  ) usp_baud_inst (
    .clk(clk),
    .rst_n(rst_n),
    .run(baud_run),
    .high_speed_baud_select(s.high_speed_baud_select),
    .baud_divisor(s.baud_divisor),
    .os_tick(os_tick)
  );

  usp_rx usp_rx_inst (
    .clk(clk),
    .rst_n(rst_n),
    .os_tick(os_tick),
    .enable(rx_enable),
    .nine_bit(s.nine_bit_rx_select),
    .rx_line(s.rx_sync),
    .frame_done(rx_done),
    .frame_data(rx_data),
    .frame_err(rx_framing_error)
  );

  // ********************************
  // Next state
  // ********************************
  always_comb
  begin
    logic req;
    logic acc;
    logic wr_byte;
    logic [3:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic txbuf_wr;
    req = avs_read || avs_write;
    acc = req && !s.waitrequest;
    idx = avs_address[5:2];
    wd = avs_writedata[7:0];
    wr_byte = acc && avs_write && avs_byteenable[0];
    txbuf_wr = wr_byte && idx == USP_IDX_TXBUF;
    rd = 8'h00;
    next_s = s;

    // Pin input synchroniser.
    next_s.rx_meta = dt_rx_in;
    next_s.rx_sync = s.rx_meta;

    // One wait state per access; read data is latched during it.
    next_s.waitrequest = !(req && s.waitrequest);
    case (idx)
      USP_IDX_INTCTL: rd = s.interrupt_master_control;
      USP_IDX_PFLAG:
      begin
        rd[USP_RCIRQ_BIT] = s.receive_complete_flag;
        rd[USP_TXIRQ_BIT] = s.transmit_buffer_empty_flag;
      end
      USP_IDX_PEN: rd = s.peripheral_enable_one;
      USP_IDX_PPRI: rd = s.peripheral_priority_one;
      USP_IDX_RXCTL:
      begin
        rd[USP_PE_BIT] = s.port_enable;
        rd[USP_RX9_BIT] = s.nine_bit_rx_select;
        rd[USP_SINGLE_RECEIVE_ENABLE_BIT] = s.single_receive_enable;
        rd[USP_CONTINUOUS_RECEIVE_ENABLE_BIT] = s.continuous_receive_enable;
        rd[USP_ADDRESS_DETECT_ENABLE_BIT] = s.address_detect_enable;
        // R19 errors beside ninth bit
        rd[USP_FRAMING_ERROR_BIT] = s.framing_error;
        rd[USP_OVERRUN_ERROR_BIT] = s.overrun_error;
        rd[USP_RX_NINTH_BIT_BIT] = s.rx_ninth_bit;
      end
      USP_IDX_TXBUF: rd = s.transmit_buffer;
      USP_IDX_TXCTL:
      begin
        rd[USP_CLOCK_SOURCE_MASTER_SELECT_BIT] = s.clock_source_master_select;
        rd[USP_TX9_BIT] = s.nine_bit_tx_select;
        rd[USP_TRANSMIT_ENABLE_BIT] = s.transmit_enable;
        rd[USP_SYNC_BIT] = s.sync_mode;
        rd[USP_HIGH_SPEED_BAUD_SELECT_BIT] = s.high_speed_baud_select;
        // R13 shift empty status
        rd[USP_SHIFT_EMPTY_STATUS_BIT] = !tx_busy;
        rd[USP_TX_NINTH_BIT_BIT] = s.tx_ninth_bit;
      end
      USP_IDX_BAUD: rd = s.baud_divisor;
      USP_IDX_RXBUF: rd = s.receive_buffer;
      default: rd = 8'h00;
    endcase
    if (req && s.waitrequest)
      next_s.readdata = {24'h000000, rd};

    // Register writes.
    if (wr_byte)
    begin
      case (idx)
        USP_IDX_INTCTL: next_s.interrupt_master_control = wd;
        USP_IDX_PEN: next_s.peripheral_enable_one = wd;
        USP_IDX_PPRI: next_s.peripheral_priority_one = wd;
        USP_IDX_RXCTL:
        begin
          // R21 pin ownership
          next_s.port_enable = wd[USP_PE_BIT];
          next_s.nine_bit_rx_select = wd[USP_RX9_BIT];
          next_s.single_receive_enable = wd[USP_SINGLE_RECEIVE_ENABLE_BIT];
          next_s.continuous_receive_enable = wd[USP_CONTINUOUS_RECEIVE_ENABLE_BIT];
          next_s.address_detect_enable = wd[USP_ADDRESS_DETECT_ENABLE_BIT];
          // R19 clear by continuous_receive_enable
          if (!wd[USP_CONTINUOUS_RECEIVE_ENABLE_BIT])
          begin
            next_s.framing_error = 1'b0;
            next_s.overrun_error = 1'b0;
          end
        end
        USP_IDX_TXBUF:
        begin
          // R11 cleared by buffer write
          next_s.transmit_buffer = wd;
          next_s.tx_buf_full = 1'b1;
          next_s.transmit_buffer_empty_flag = 1'b0;
        end
        USP_IDX_TXCTL:
        begin
          next_s.clock_source_master_select = wd[USP_CLOCK_SOURCE_MASTER_SELECT_BIT];
          next_s.nine_bit_tx_select = wd[USP_TX9_BIT];
          next_s.transmit_enable = wd[USP_TRANSMIT_ENABLE_BIT];
          // R8 mode select
          next_s.sync_mode = wd[USP_SYNC_BIT];
          // R4 speed select
          next_s.high_speed_baud_select = wd[USP_HIGH_SPEED_BAUD_SELECT_BIT];
          next_s.tx_ninth_bit = wd[USP_TX_NINTH_BIT_BIT];
          // R14 enable sets flag
          if (wd[USP_TRANSMIT_ENABLE_BIT] && !s.transmit_enable && !s.tx_buf_full)
            next_s.transmit_buffer_empty_flag = 1'b1;
        end
        USP_IDX_BAUD: next_s.baud_divisor = wd;
        default: next_s.baud_divisor = s.baud_divisor;
      endcase
    end

    // Reading the receive buffer frees it.
    if (acc && avs_read && idx == USP_IDX_RXBUF)
      next_s.receive_complete_flag = 1'b0;

    // ********************************
    // Receive completion
    // ********************************
    // R20 R23 address filter
    if (rx_done && !(s.nine_bit_rx_select && s.address_detect_enable && !rx_data[8]))
    begin
      if (s.receive_complete_flag && !(acc && avs_read && idx == USP_IDX_RXBUF))
      begin
        next_s.overrun_error = 1'b1;
      end
      else
      begin
        // R18 receive complete
        next_s.receive_buffer = rx_data[7:0];
        // R6 ninth bit stored unchecked
        next_s.rx_ninth_bit = rx_data[8];
        next_s.framing_error = rx_framing_error;
        next_s.receive_complete_flag = 1'b1;
      end
    end

    // ********************************
    // Transmitter
    // ********************************
    case (s.txs)
      USP_TX_IDLE:
      begin
        // R9 R10 one cycle reload
        if (s.tx_buf_full && s.transmit_enable && baud_run && !txbuf_wr)
        begin
          // R15 ninth bit
          next_s.tx_shift_register = {s.nine_bit_tx_select & s.tx_ninth_bit,
                                      s.transmit_buffer};
          next_s.tx_buf_full = 1'b0;
          next_s.transmit_buffer_empty_flag = 1'b1;
          next_s.tx_bits = 4'h0;
          next_s.tx_os = 4'h0;
          next_s.txs = s.sync_mode ? USP_TX_DATA : USP_TX_START;
        end
      end
      USP_TX_START:
        if (os_tick)
        begin
          next_s.tx_os = s.tx_os + 4'h1;
          if (s.tx_os == USP_OS_LAST)
            next_s.txs = USP_TX_DATA;
        end
      USP_TX_DATA:
        if (os_tick)
        begin
          next_s.tx_os = s.tx_os + 4'h1;
          if (s.tx_os == USP_OS_LAST)
          begin
            // R2 shift lsb first
            next_s.tx_shift_register = {1'b0, s.tx_shift_register[8:1]};
            next_s.tx_bits = s.tx_bits + 4'h1;
            // R1 eight or nine bits
            if (s.tx_bits == (s.nine_bit_tx_select ? USP_BITS_9 : USP_BITS_8))
              next_s.txs = s.sync_mode ? USP_TX_IDLE : USP_TX_STOP;
          end
        end
      USP_TX_STOP:
        if (os_tick)
        begin
          next_s.tx_os = s.tx_os + 4'h1;
          if (s.tx_os == USP_OS_LAST)
            next_s.txs = USP_TX_IDLE;
        end
      default:
        next_s.txs = USP_TX_IDLE;
    endcase
    if (!baud_run || !s.transmit_enable)
      next_s.txs = USP_TX_IDLE;

    // ********************************
    // Pins
    // ********************************
    next_s.ck_oe_n = !s.port_enable;
    next_s.dt_oe_n = 1'b1;
    next_s.dt_out = 1'b1;
    case (s.txs)
      USP_TX_START: next_s.ck_out = 1'b0;
      USP_TX_DATA: next_s.ck_out = s.tx_shift_register[0];
      default: next_s.ck_out = 1'b1;
    endcase
    if (s.sync_mode && s.port_enable)
    begin
      // R22 master clock and data
      next_s.ck_oe_n = !s.clock_source_master_select;
      next_s.ck_out = (s.txs == USP_TX_DATA) ? (s.tx_os >= USP_OS_HALF) : 1'b1;
      next_s.dt_oe_n = !tx_busy;
      next_s.dt_out = s.tx_shift_register[0];
    end

    // R12 R18 interrupt requests
    next_s.tx_irq = s.transmit_buffer_empty_flag && s.peripheral_enable_one[USP_TXIRQ_BIT];
    next_s.rx_irq = s.receive_complete_flag && s.peripheral_enable_one[USP_RCIRQ_BIT];
    next_s.cpu_irq = (s.tx_irq || s.rx_irq) && s.interrupt_master_control[USP_GIE_BIT]
                     && s.interrupt_master_control[USP_PEIE_BIT];
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.waitrequest <= 1'b1;
      s.interrupt_master_control <= USP_RST_REG;
      s.peripheral_enable_one <= USP_RST_REG;
      s.peripheral_priority_one <= USP_RST_REG;
      s.baud_divisor <= USP_RST_REG;
      s.txs <= USP_TX_IDLE;
      s.rx_meta <= 1'b1;
      s.rx_sync <= 1'b1;
      s.ck_out <= 1'b1;
      s.ck_oe_n <= 1'b1;
      s.dt_out <= 1'b1;
      s.dt_oe_n <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign avs_readdata = s.readdata;
  assign avs_waitrequest = s.waitrequest;
  assign ck_tx_out = s.ck_out;
  assign ck_tx_oe_n = s.ck_oe_n;
  assign dt_rx_out = s.dt_out;
  assign dt_rx_oe_n = s.dt_oe_n;
  assign tx_irq = s.tx_irq;
  assign rx_irq = s.rx_irq;
  assign cpu_irq = s.cpu_irq;

endmodule // usp_top

// ### tb/usp_top_asserts.sv
// Concurrent checks on the serial port's bus, line pins and interrupt outputs.
`timescale 1ns/100ps
module usp_top_asserts
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Power and pins
  input wire logic sleep_mode,
  input wire logic ck_tx_out,
  input wire logic ck_tx_oe_n,
  input wire logic dt_rx_oe_n,
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic cpu_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("Bus request not answered after one wait state.");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("Wait request low for more than one cycle.");
  property p_rdata_byte;
    avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rdata_byte: assert property (p_rdata_byte)
    else $error("Read data upper bits not zero.");
  property p_start_min;
    $fell(ck_tx_out) && !ck_tx_oe_n |=> !ck_tx_out [*8];
  endproperty
  a_start_min: assert property (p_start_min)
    else $error("Low level on transmit line shorter than a bit.");
  property p_bit_min;
    $rose(ck_tx_out) && !ck_tx_oe_n |=> ck_tx_out [*8];
  endproperty
  a_bit_min: assert property (p_bit_min)
    else $error("High level on transmit line shorter than a bit.");
  property p_sleep_hold;
    sleep_mode && $past(sleep_mode) && $past(sleep_mode, 2) && $past(sleep_mode, 3)
      |-> $stable(ck_tx_out);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("Transmit line moved while sleeping.");
  property p_cpu_irq;
    cpu_irq |-> $past(tx_irq || rx_irq);
  endproperty
  a_cpu_irq: assert property (p_cpu_irq)
    else $error("Processor interrupt without a source request.");
  property p_pin_pair;
    ck_tx_oe_n |-> dt_rx_oe_n;
  endproperty
  a_pin_pair: assert property (p_pin_pair)
    else $error("Data pin driven while port pins are released.");
endmodule // usp_top_asserts

bind usp_top usp_top_asserts usp_top_asserts_inst (.clk(clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sleep_mode(sleep_mode), .ck_tx_out(ck_tx_out),
  .ck_tx_oe_n(ck_tx_oe_n), .dt_rx_oe_n(dt_rx_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq),
  .cpu_irq(cpu_irq));

// ### tb/usp_node.sv
// Remote serial node: decodes frames from the port and sends frames to it.
`timescale 1ns/100ps
module usp_node
(
  // Clock
  input wire logic clk,
  // Line format
  input wire logic [7:0] bit_clks,
  input wire logic nine,
  // Line
  input wire logic line_in,
  output logic line_out
);
  logic [9:0] got = 10'h3ff;
  logic [9:0] sh;
  int got_cnt = 0;

  initial line_out = 1'b1;

  always @(negedge line_in)
  begin
    sh = 10'h3ff;
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < (nine ? 10 : 9); i++)
    begin
      repeat (bit_clks) @(posedge clk);
      sh = {line_in, sh[9:1]};
    end
    got = sh;
    got_cnt++;
  end

  task automatic send(input logic [8:0] d, input logic stop);
    logic [10:0] f;
    f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      line_out <= f[i];
      repeat (bit_clks) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask
endmodule // usp_node

// ### tb/test_usart_async_serial_port.sv
// Self-checking bench for the serial port: register tasks and line tests.
`timescale 1ns/100ps
module test_usart_async_serial_port;
  import usp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sleep_mode = 1'b0;
  logic ck_tx_out, ck_tx_oe_n, dt_rx_out, dt_rx_oe_n, tx_irq, rx_irq, cpu_irq;
  logic rx_line;
  logic [7:0] bit_clks = 8'h10;
  logic nine = 1'b0;
  logic [7:0] rd_data;
  int fails = 0;
  int comparisons = 0;
  // The transmit pin has a pull-up when the port releases it.
  wire logic tx_wire = ck_tx_oe_n ? 1'b1 : ck_tx_out;

  always #50 clk = ~clk;

  usp_top usp_top_inst (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sleep_mode(sleep_mode), .ck_tx_in(1'b1), .ck_tx_out(ck_tx_out), .ck_tx_oe_n(ck_tx_oe_n),
    .dt_rx_in(rx_line), .dt_rx_out(dt_rx_out), .dt_rx_oe_n(dt_rx_oe_n), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .cpu_irq(cpu_irq));
  usp_node usp_node_inst (.clk(clk), .bit_clks(bit_clks), .nine(nine), .line_in(tx_wire),
    .line_out(rx_line));

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rd_data = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [3:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk({2'b00, rd_data}, {2'b00, exp});
  endtask

  task automatic tx_idle;
    bus(1'b0, USP_IDX_TXCTL, 8'h00);
    while (rd_data[USP_SHIFT_EMPTY_STATUS_BIT] !== 1'b1)
      bus(1'b0, USP_IDX_TXCTL, 8'h00);
  endtask

  task automatic wait_cnt(input int n);
    while (usp_node_inst.got_cnt < n)
      @(posedge clk);
  endtask

  task automatic wait_rx;
    while (rx_irq !== 1'b1)
      @(posedge clk);
  endtask

  task finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #2000000;
    fails++;
    finish_test;
  end

  // ********
  // Tests
  // ********
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(USP_IDX_TXCTL, 8'h02);
    for (int i = 0; i < 10; i++)
      if (i[3:0] != USP_IDX_TXCTL)
        rchk(i[3:0], 8'h00);
    chk({8'h00, ck_tx_oe_n, dt_rx_oe_n}, 10'h003);
    $display("reset test done");
    bus(1'b1, USP_IDX_BAUD, 8'h00);
    bus(1'b1, USP_IDX_RXCTL, 8'h90);
    bus(1'b1, USP_IDX_TXCTL, 8'h24);
    chk({8'h00, ck_tx_oe_n, dt_rx_oe_n}, 10'h001);
    rchk(USP_IDX_PFLAG, 8'h10);
    bus(1'b1, USP_IDX_TXBUF, 8'ha5);
    bus(1'b1, USP_IDX_TXBUF, 8'h3c);
    rchk(USP_IDX_PFLAG, 8'h00);
    rchk(USP_IDX_TXCTL, 8'h24);
    wait_cnt(1);
    chk(usp_node_inst.got, {1'b1, 8'ha5, 1'b1});
    wait_cnt(2);
    chk(usp_node_inst.got, {1'b1, 8'h3c, 1'b1});
    tx_idle;
    rchk(USP_IDX_PFLAG, 8'h10);
    bus(1'b1, USP_IDX_PFLAG, 8'h00);
    rchk(USP_IDX_PFLAG, 8'h10);
    bus(1'b1, USP_IDX_PEN, 8'h10);
    @(posedge clk);
    chk({8'h00, tx_irq, cpu_irq}, 10'h002);
    bus(1'b1, USP_IDX_INTCTL, 8'hc0);
    @(posedge clk);
    chk({9'h000, cpu_irq}, 10'h001);
    $display("transmit test done");
    nine <= 1'b1;
    bus(1'b1, USP_IDX_TXCTL, 8'h65);
    bus(1'b1, USP_IDX_TXBUF, 8'h5a);
    wait_cnt(3);
    chk(usp_node_inst.got, {2'b11, 8'h5a});
    tx_idle;
    nine <= 1'b0;
    bit_clks <= 8'h40;
    bus(1'b1, USP_IDX_TXCTL, 8'h20);
    bus(1'b1, USP_IDX_TXBUF, 8'h81);
    wait_cnt(4);
    chk(usp_node_inst.got, {1'b1, 8'h81, 1'b1});
    tx_idle;
    $display("speed test done");
    bit_clks <= 8'h10;
    bus(1'b1, USP_IDX_TXCTL, 8'h24);
    bus(1'b1, USP_IDX_PEN, 8'h20);
    usp_node_inst.send(9'h03c, 1'b1);
    wait_rx;
    rchk(USP_IDX_PFLAG, 8'h30);
    rchk(USP_IDX_RXBUF, 8'h3c);
    rchk(USP_IDX_PFLAG, 8'h10);
    nine <= 1'b1;
    bus(1'b1, USP_IDX_RXCTL, 8'hd8);
    usp_node_inst.send(9'h011, 1'b1);
    repeat (8) @(posedge clk);
    chk({9'h000, rx_irq}, 10'h000);
    usp_node_inst.send(9'h122, 1'b1);
    wait_rx;
    rchk(USP_IDX_RXCTL, 8'hd9);
    rchk(USP_IDX_RXBUF, 8'h22);
    bus(1'b1, USP_IDX_RXCTL, 8'hd0);
    usp_node_inst.send(9'h033, 1'b1);
    wait_rx;
    rchk(USP_IDX_RXBUF, 8'h33);
    $display("receive test done");
    nine <= 1'b0;
    bus(1'b1, USP_IDX_RXCTL, 8'h90);
    usp_node_inst.send(9'h044, 1'b0);
    wait_rx;
    rchk(USP_IDX_RXCTL, 8'h94);
    rchk(USP_IDX_RXBUF, 8'h44);
    bus(1'b1, USP_IDX_RXCTL, 8'h80);
    rchk(USP_IDX_RXCTL, 8'h80);
    sleep_mode <= 1'b1;
    bus(1'b1, USP_IDX_TXBUF, 8'h69);
    repeat (200) @(posedge clk);
    chk(10'(usp_node_inst.got_cnt), 10'h004);
    sleep_mode <= 1'b0;
    wait_cnt(5);
    chk(usp_node_inst.got, {1'b1, 8'h69, 1'b1});
    chk({8'h00, dt_rx_oe_n, dt_rx_out}, 10'h003);
    $display("error and sleep test done");
    finish_test;
  end
endmodule // test_usart_async_serial_port
